/* rtl/spr_assist_params.svh */
// Purpose: numbers of the special purpose register map and its assist fields
// Assumes: register numbers are the 10-bit decoded numbers, not the instruction field
// Notes:   definitions only
`ifndef SPR_ASSIST_PARAMS_SVH
`define SPR_ASSIST_PARAMS_SVH

// register numbers
`define SPR_NUM_SCRATCH_4     10'h114
`define SPR_NUM_SCRATCH_5     10'h115
`define SPR_NUM_SCRATCH_6     10'h116
`define SPR_NUM_SCRATCH_7     10'h117
`define SPR_NUM_EVENT_SEL     10'h3B9
`define SPR_NUM_MODE_CTRL     10'h3BA
`define SPR_NUM_PTE_COMPARE   10'h3D1
`define SPR_NUM_PTEG_PRIMARY  10'h3D2
`define SPR_NUM_PTEG_SECOND   10'h3D3
`define SPR_NUM_LRU_WRITE_A   10'h3D6
`define SPR_NUM_RECENT_FAULT  10'h3D7
`define SPR_NUM_BKPT_CTRL     10'h3D9
`define SPR_NUM_LRU_WRITE_B   10'h3DB
`define SPR_NUM_MISS_STATUS   10'h3DC
`define SPR_NUM_MISS_ADDRESS  10'h3DD
`define SPR_NUM_MCHK_CTRL     10'h3F0
`define SPR_NUM_IBKPT_ADDR    10'h3F2
`define SPR_NUM_L2_DATA       10'h3F4
`define SPR_NUM_DBKPT_COMPAT  10'h3F5
`define SPR_NUM_DBKPT_EXT     10'h3F6
`define SPR_NUM_L2_CTRL       10'h3FB
`define SPR_NUM_PROC_ID       10'h3FF

// reset values
`define MISS_ADDRESS_RESET    32'h0000_0000
`define MISS_STATUS_RESET     32'h0000_0000
`define STORE_WORD_RESET      32'h0000_0000

// field positions, little-endian bit numbers
`define MAR_SEG_LSB           28
`define MAR_API_LSB           22
`define MAR_PAGE_LSB          12
`define TLB_MISS_STATUS_WAY_LSB          23
`define BASE_ORG_HI_LSB       25
`define BASE_ORG_MID_LSB      16

// timing: request taken to reply
`define ACCESS_CYCLES         2

`endif

/* rtl/spr_assist_pkg.sv */
// Purpose: types shared by the register map modules
// Assumes: nothing
// Notes:   numbers live in spr_assist_params.svh
package spr_assist_pkg;

   // access sequence, gray along idle-lookup-reply
   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'h0,
      ST_LOOKUP = 2'h1,
      ST_REPLY  = 2'h3
   } access_state_t;

   // what a decoded register number selects
   typedef enum logic [3:0]
   {
      SEL_NONE, SEL_STORE, SEL_MAR, SEL_TLB_MISS_STATUS, SEL_CMP,
      SEL_PRIMARY_PTEG_ADDRESS, SEL_SECONDARY_PTEG_ADDRESS, SEL_LRU_A, SEL_LRU_B, SEL_MRF
   } reg_sel_t;

endpackage : spr_assist_pkg

/* rtl/assist_if.sv */
// Purpose: carries the live page table inputs and derived words
// Assumes: all signals combinational within one clock domain
// Notes:   calc is the hash unit side
`timescale 1ns/10ps
interface assist_if;
   logic [31:0] miss_address;
   logic [31:0] table_base;
   logic [23:0] vsid;
   logic [31:0] compare_word;
   logic [31:0] hash_primary;
   logic [31:0] hash_secondary;

   modport calc (input miss_address, table_base, vsid,
                 output compare_word, hash_primary, hash_secondary);
   modport user (output miss_address, table_base, vsid,
                 input compare_word, hash_primary, hash_secondary);
endinterface : assist_if

/* rtl/pteg_hash_unit.sv */
// Purpose: compare word and both group addresses from base, address, segment
// Assumes: base holds origin in 31:16 and mask in 8:0
// Notes:   purely combinational, so values follow their inputs at once
`timescale 1ns/10ps
`include "spr_assist_params.svh"
module pteg_hash_unit
(
   assist_if.calc port_a
);
   logic [18:0] hash_one;
   logic [18:0] hash_two;

   // primary hash is low segment id bits xor page index; secondary is its complement
   assign hash_one = port_a.vsid[18:0]
                   ^ {3'h0, port_a.miss_address[`MAR_PAGE_LSB +: 16]};
   assign hash_two = ~hash_one;

   // valid set, segment id, primary hash flag clear, abbreviated page index
   assign port_a.compare_word = {1'b1, port_a.vsid, 1'b0,
                                 port_a.miss_address[`MAR_API_LSB +: 6]};

   // masked upper hash bits merge into the origin, low six bits are zero
   assign port_a.hash_primary = {port_a.table_base[`BASE_ORG_HI_LSB +: 7],
      port_a.table_base[`BASE_ORG_MID_LSB +: 9] | (hash_one[18:10] & port_a.table_base[8:0]),
      hash_one[9:0], 6'h00};
   assign port_a.hash_secondary = {port_a.table_base[`BASE_ORG_HI_LSB +: 7],
      port_a.table_base[`BASE_ORG_MID_LSB +: 9] | (hash_two[18:10] & port_a.table_base[8:0]),
      hash_two[9:0], 6'h00};
endmodule : pteg_hash_unit

/* rtl/spr_word_store.sv */
// Purpose: small word memory for plain read/write registers
// Assumes: one write and one read per cycle
// Notes:   read data come out of a register one cycle after the index
`timescale 1ns/10ps
`include "spr_assist_params.svh"
module spr_word_store
#(
   parameter int DEPTH = 14,
   parameter int WIDTH = 32
)
(
   input  wire logic                     clock,
   input  wire logic                     reset,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_index,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_index,
   output logic      [WIDTH-1:0]         rd_data
);
   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] words;
      logic [WIDTH-1:0]            rd;
   } store_state_t;

   store_state_t s_reg;
   store_state_t s_next;

   initial
   begin
      if (DEPTH < 2 || WIDTH < 1 || WIDTH > 32)
         $error("spr_word_store: unsupported size");
   end

   // write-through is not offered: a read in the write cycle sees the old word
   always_comb
   begin
      s_next    = s_reg;
      s_next.rd = s_reg.words[rd_index];
      if (wr_en)
         s_next.words[wr_index] = wr_data;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
         s_reg <= '{words: {DEPTH{WIDTH'(`STORE_WORD_RESET)}}, rd: WIDTH'(`STORE_WORD_RESET)};
      else
         s_reg <= s_next;
   end

   assign rd_data = s_reg.rd;
endmodule : spr_word_store

/* rtl/spr_map_tlb_miss_assist.sv */
// Purpose: special purpose register map with TLB miss assist registers
// Assumes: the core sends one move-to/move-from request at a time; TLB and
//          segment registers live outside and answer combinationally
// Notes:   requests answer two cycles after they are taken
// Contract
// RULE_01: TLB interrupt loads miss address register
// RULE_02: capture fetch address or data address
// RULE_03: miss address is readable and writable
// RULE_04: interrupt records address and type together
// RULE_05: compare and hash reads use live inputs
// RULE_06: derived values follow base, address, segment
// RULE_07: LRU write picks set from present address
// RULE_08: LRU translation joins data, address, segment
// RULE_09: recent-fault entry chosen by address and status
// RULE_10: handlers keep inputs steady while using assists
// RULE_11: change inputs only with relocation off
// RULE_12: decode assist registers at their numbers
// RULE_13: four extra scratch registers 276 to 279
// RULE_14: problem-state access to these is refused
// RULE_15: writing compare register is invalid
// RULE_16: reading LRU write registers is invalid
// RULE_17: LRU write replaces least recent entry
// RULE_18: instruction field halves swapped for number
`timescale 1ns/10ps
`include "spr_assist_params.svh"
module spr_map_tlb_miss_assist
#(
   parameter int SET_BITS = 5
)
(
   input  wire logic                clock,
   input  wire logic                reset,
   input  wire logic                spr_req,
   input  wire logic                spr_write,
   input  wire logic [9:0]          spr_field,
   input  wire logic [31:0]         spr_wdata,
   input  wire logic                problem_state,
   output logic                     spr_ready,
   output logic                     spr_done,
   output logic                     spr_hit,
   output logic                     spr_priv_fault,
   output logic                     spr_invalid,
   output logic [31:0]              spr_rdata,
   input  wire logic                tlb_int_take,
   input  wire logic                tlb_int_is_fetch,
   input  wire logic [31:0]         tlb_int_iaddr,
   input  wire logic [31:0]         tlb_int_daddr,
   input  wire logic [31:0]         tlb_int_status,
   input  wire logic [31:0]         page_table_base,
   output logic [3:0]               seg_index,
   input  wire logic [23:0]         seg_vsid,
   output logic                     tlb_lru_wr,
   output logic                     tlb_lru_sel_b,
   output logic                     tlb_mrf_rd,
   output logic                     tlb_mrf_wr,
   output logic [SET_BITS-1:0]      tlb_set,
   output logic [1:0]               tlb_way,
   output logic [31:0]              tlb_entry_hi,
   output logic [31:0]              tlb_entry_lo,
   input  wire logic [31:0]         tlb_mrf_rdata
);
   localparam int STORE_DEPTH = 14;

   typedef struct packed
   {
      spr_assist_pkg::access_state_t st;
      spr_assist_pkg::reg_sel_t      sel;
      logic                          hit;
      logic                          priv;
      logic                          inval;
      logic [31:0]                   tlb_miss_address;
      logic [31:0]                   tlb_miss_status;
      logic [31:0]                   rdata;
      logic                          lru_wr;
      logic                          lru_b;
      logic                          mrf_rd;
      logic                          mrf_wr;
      logic [SET_BITS-1:0]           set;
      logic [1:0]                    way;
      logic [31:0]                   hi;
      logic [31:0]                   lo;
   } map_state_t;

   map_state_t                  s_reg;
   map_state_t                  s_next;
   logic [9:0]                  spr_num;
   spr_assist_pkg::reg_sel_t    dec_sel;
   logic [3:0]                  dec_idx;
   logic                        take;
   logic                        allowed;
   logic                        store_wr;
   logic [31:0]                 store_rd;
   logic [SET_BITS-1:0]         mar_set;
   logic [1:0]                  tlb_miss_status_way;
   assist_if                    assist ();

   initial
   begin
      if (SET_BITS < 1 || SET_BITS > 16)
         $error("spr_map_tlb_miss_assist: SET_BITS out of range");
   end

   // low half of the instruction field is the high half of the number
   assign spr_num = {spr_field[4:0], spr_field[9:5]}; // RULE_18

   // register number decode; anything else belongs to other units
   always_comb
   begin
      dec_sel = spr_assist_pkg::SEL_STORE;
      dec_idx = 4'h0;
      case (spr_num)
         `SPR_NUM_SCRATCH_4:    dec_idx = 4'h0; // RULE_13
         `SPR_NUM_SCRATCH_5:    dec_idx = 4'h1; // RULE_13
         `SPR_NUM_SCRATCH_6:    dec_idx = 4'h2; // RULE_13
         `SPR_NUM_SCRATCH_7:    dec_idx = 4'h3; // RULE_13
         `SPR_NUM_EVENT_SEL:    dec_idx = 4'h4;
         `SPR_NUM_MODE_CTRL:    dec_idx = 4'h5;
         `SPR_NUM_BKPT_CTRL:    dec_idx = 4'h6;
         `SPR_NUM_MCHK_CTRL:    dec_idx = 4'h7;
         `SPR_NUM_IBKPT_ADDR:   dec_idx = 4'h8;
         `SPR_NUM_L2_DATA:      dec_idx = 4'h9;
         `SPR_NUM_DBKPT_COMPAT: dec_idx = 4'hA;
         `SPR_NUM_DBKPT_EXT:    dec_idx = 4'hB;
         `SPR_NUM_L2_CTRL:      dec_idx = 4'hC;
         `SPR_NUM_PROC_ID:      dec_idx = 4'hD;
         `SPR_NUM_MISS_ADDRESS: dec_sel = spr_assist_pkg::SEL_MAR; // RULE_12
         `SPR_NUM_MISS_STATUS:  dec_sel = spr_assist_pkg::SEL_TLB_MISS_STATUS; // RULE_12
         `SPR_NUM_PTE_COMPARE:  dec_sel = spr_assist_pkg::SEL_CMP; // RULE_12
         `SPR_NUM_PTEG_PRIMARY: dec_sel = spr_assist_pkg::SEL_PRIMARY_PTEG_ADDRESS; // RULE_12
         `SPR_NUM_PTEG_SECOND:  dec_sel = spr_assist_pkg::SEL_SECONDARY_PTEG_ADDRESS; // RULE_12
         `SPR_NUM_LRU_WRITE_A:  dec_sel = spr_assist_pkg::SEL_LRU_A; // RULE_12
         `SPR_NUM_LRU_WRITE_B:  dec_sel = spr_assist_pkg::SEL_LRU_B; // RULE_12
         `SPR_NUM_RECENT_FAULT: dec_sel = spr_assist_pkg::SEL_MRF; // RULE_12
         default:               dec_sel = spr_assist_pkg::SEL_NONE;
      endcase
   end

   // privilege first, then direction checks; a refused access changes nothing
   assign take    = spr_req && (s_reg.st == spr_assist_pkg::ST_IDLE);
   assign allowed = take && (dec_sel != spr_assist_pkg::SEL_NONE) && !problem_state // RULE_14
      && !(spr_write && (dec_sel == spr_assist_pkg::SEL_CMP // RULE_15
                      || dec_sel == spr_assist_pkg::SEL_PRIMARY_PTEG_ADDRESS
                      || dec_sel == spr_assist_pkg::SEL_SECONDARY_PTEG_ADDRESS))
      && !(!spr_write && (dec_sel == spr_assist_pkg::SEL_LRU_A // RULE_16
                       || dec_sel == spr_assist_pkg::SEL_LRU_B));
   assign store_wr = allowed && spr_write && (dec_sel == spr_assist_pkg::SEL_STORE);

   // set and way always from the present registers, never a saved copy
   assign mar_set  = s_reg.tlb_miss_address[`MAR_PAGE_LSB +: SET_BITS]; // RULE_07
   assign tlb_miss_status_way = s_reg.tlb_miss_status[`TLB_MISS_STATUS_WAY_LSB +: 2]; // RULE_09

   // live derivation inputs
   assign assist.miss_address = s_reg.tlb_miss_address; // RULE_06
   assign assist.table_base   = page_table_base; // RULE_06
   assign assist.vsid         = seg_vsid; // RULE_06
   assign seg_index           = s_reg.tlb_miss_address[`MAR_SEG_LSB +: 4];

   pteg_hash_unit u_hash
   (
      .port_a (assist.calc)
   );

   spr_word_store #(.DEPTH(STORE_DEPTH), .WIDTH(32)) u_store
   (
      .clock    (clock),
      .reset    (reset),
      .wr_en    (store_wr),
      .wr_index (dec_idx),
      .wr_data  (spr_wdata),
      .rd_index (dec_idx),
      .rd_data  (store_rd)
   );

   // access sequence and register effects
   always_comb
   begin
      s_next        = s_reg;
      s_next.lru_wr = 1'b0;
      s_next.mrf_rd = 1'b0;
      s_next.mrf_wr = 1'b0;
      case (s_reg.st)
         spr_assist_pkg::ST_IDLE:
         begin
            if (take)
            begin
               s_next.st    = spr_assist_pkg::ST_LOOKUP;
               s_next.sel   = spr_write ? spr_assist_pkg::SEL_NONE : dec_sel;
               s_next.hit   = (dec_sel != spr_assist_pkg::SEL_NONE);
               s_next.priv  = (dec_sel != spr_assist_pkg::SEL_NONE) && problem_state;
               s_next.inval = (dec_sel != spr_assist_pkg::SEL_NONE) && !problem_state
                              && !allowed;
               if (!allowed)
                  s_next.sel = spr_assist_pkg::SEL_NONE;
               else if (spr_write)
               begin
                  case (dec_sel)
                     spr_assist_pkg::SEL_MAR:  s_next.tlb_miss_address  = spr_wdata; // RULE_03
                     spr_assist_pkg::SEL_TLB_MISS_STATUS: s_next.tlb_miss_status = spr_wdata;
                     spr_assist_pkg::SEL_LRU_A, spr_assist_pkg::SEL_LRU_B:
                     begin
                        s_next.lru_wr = 1'b1; // RULE_17
                        s_next.lru_b  = (dec_sel == spr_assist_pkg::SEL_LRU_B);
                        s_next.set    = mar_set; // RULE_07
                        s_next.hi     = assist.compare_word; // RULE_08
                        s_next.lo     = spr_wdata; // RULE_08
                     end
                     spr_assist_pkg::SEL_MRF:
                     begin
                        s_next.mrf_wr = 1'b1;
                        s_next.set    = mar_set; // RULE_09
                        s_next.way    = tlb_miss_status_way; // RULE_09
                        s_next.lo     = spr_wdata;
                     end
                     default: s_next.mrf_wr = 1'b0;
                  endcase
               end
               else if (dec_sel == spr_assist_pkg::SEL_MRF)
               begin
                  s_next.mrf_rd = 1'b1;
                  s_next.set    = mar_set; // RULE_09
                  s_next.way    = tlb_miss_status_way; // RULE_09
               end
            end
         end
         spr_assist_pkg::ST_LOOKUP:
         begin
            s_next.st = spr_assist_pkg::ST_REPLY;
            // derived words are sampled now, so they reflect the latest writes
            case (s_reg.sel)
               spr_assist_pkg::SEL_STORE: s_next.rdata = store_rd;
               spr_assist_pkg::SEL_MAR:   s_next.rdata = s_reg.tlb_miss_address; // RULE_03
               spr_assist_pkg::SEL_TLB_MISS_STATUS:  s_next.rdata = s_reg.tlb_miss_status;
               spr_assist_pkg::SEL_CMP:   s_next.rdata = assist.compare_word; // RULE_05
               spr_assist_pkg::SEL_PRIMARY_PTEG_ADDRESS: s_next.rdata = assist.hash_primary; // RULE_05
               spr_assist_pkg::SEL_SECONDARY_PTEG_ADDRESS: s_next.rdata = assist.hash_secondary; // RULE_05
               spr_assist_pkg::SEL_MRF:   s_next.rdata = tlb_mrf_rdata;
               default:                   s_next.rdata = 32'h0000_0000;
            endcase
         end
         spr_assist_pkg::ST_REPLY: s_next.st = spr_assist_pkg::ST_IDLE;
         default:                  s_next.st = spr_assist_pkg::ST_IDLE;
      endcase
      // capture wins over a software write in the same cycle
      if (tlb_int_take)
      begin
         s_next.tlb_miss_address  = tlb_int_is_fetch ? tlb_int_iaddr : tlb_int_daddr; // RULE_01 RULE_02
         s_next.tlb_miss_status = tlb_int_status; // RULE_04
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         s_reg      <= '0;
         s_reg.st   <= spr_assist_pkg::ST_IDLE;
         s_reg.sel  <= spr_assist_pkg::SEL_NONE;
         s_reg.tlb_miss_address  <= `MISS_ADDRESS_RESET;
         s_reg.tlb_miss_status <= `MISS_STATUS_RESET;
      end
      else
         s_reg <= s_next;
   end

   // outputs
   assign spr_ready      = (s_reg.st == spr_assist_pkg::ST_IDLE);
   assign spr_done       = (s_reg.st == spr_assist_pkg::ST_REPLY);
   assign spr_hit        = s_reg.hit;
   assign spr_priv_fault = s_reg.priv;
   assign spr_invalid    = s_reg.inval;
   assign spr_rdata      = s_reg.rdata;
   assign tlb_lru_wr     = s_reg.lru_wr;
   assign tlb_lru_sel_b  = s_reg.lru_b;
   assign tlb_mrf_rd     = s_reg.mrf_rd;
   assign tlb_mrf_wr     = s_reg.mrf_wr;
   assign tlb_set        = s_reg.set;
   assign tlb_way        = s_reg.way;
   assign tlb_entry_hi   = s_reg.hi;
   assign tlb_entry_lo   = s_reg.lo;

   // checks on the map behaviour
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   AST_CAPTURE_DATA: assert property ( // RULE_01
      tlb_int_take && !tlb_int_is_fetch |=> s_reg.tlb_miss_address == $past(tlb_int_daddr))
      else $error("miss address missed data address");
   AST_CAPTURE_FETCH: assert property ( // RULE_02
      tlb_int_take && tlb_int_is_fetch |=> s_reg.tlb_miss_address == $past(tlb_int_iaddr))
      else $error("miss address missed fetch address");
   AST_STATUS: assert property ( // RULE_04
      tlb_int_take |=> s_reg.tlb_miss_status == $past(tlb_int_status))
      else $error("miss status not captured");
   AST_MAR_WRITE: assert property ( // RULE_03
      allowed && spr_write && dec_sel == spr_assist_pkg::SEL_MAR && !tlb_int_take
      |=> s_reg.tlb_miss_address == $past(spr_wdata))
      else $error("miss address write lost");
   AST_CMP_READ: assert property ( // RULE_05
      s_reg.st == spr_assist_pkg::ST_LOOKUP && s_reg.sel == spr_assist_pkg::SEL_CMP
      |=> spr_done && spr_rdata == $past(assist.compare_word))
      else $error("compare read stale");
   AST_API_LIVE: assert property ( // RULE_06
      assist.compare_word[5:0] == s_reg.tlb_miss_address[`MAR_API_LSB +: 6])
      else $error("page index not live");
   AST_LRU_SET: assert property ( // RULE_07
      tlb_lru_wr |-> tlb_set == $past(mar_set) && tlb_entry_lo == $past(spr_wdata))
      else $error("lru write set wrong");
   AST_LRU_HI: assert property ( // RULE_08
      tlb_lru_wr |-> tlb_entry_hi == $past(assist.compare_word))
      else $error("lru translation high word wrong");
   AST_MRF_WAY: assert property ( // RULE_09
      tlb_mrf_rd || tlb_mrf_wr |-> tlb_way == $past(tlb_miss_status_way) && tlb_set == $past(mar_set))
      else $error("recent fault entry select wrong");
   AST_DECODE_MAR: assert property ( // RULE_12
      take && spr_field == 10'h3BE |-> ##2 spr_done && spr_hit)
      else $error("miss address number not decoded");
   AST_SCRATCH: assert property ( // RULE_13
      take && spr_field == 10'h288 |-> ##2 spr_done && spr_hit)
      else $error("scratch register not decoded");
   AST_PRIV: assert property ( // RULE_14
      take && problem_state && dec_sel != spr_assist_pkg::SEL_NONE
      |-> ##2 spr_done && spr_priv_fault && !spr_invalid)
      else $error("problem state access not refused");
   AST_CMP_WRITE: assert property ( // RULE_15
      take && spr_write && !problem_state && dec_sel == spr_assist_pkg::SEL_CMP
      |-> ##2 spr_invalid)
      else $error("compare write not invalid");
   AST_LRU_READ: assert property ( // RULE_16
      take && !spr_write && !problem_state && dec_sel == spr_assist_pkg::SEL_LRU_B
      |=> !tlb_lru_wr ##1 spr_invalid)
      else $error("lru read not invalid");
endmodule : spr_map_tlb_miss_assist

/* verification/spr_map_tlb_miss_assist_tb_top.sv */
// Purpose: self-checking bench for the special register map and its TLB assist words
// Assumes: two-edge answer; inputs change 1 ns after the rising edge
// Notes:   the bench plays the TLB and segment side with steady answers
`timescale 1ns/10ps
`include "spr_assist_params.svh"
module spr_map_tlb_miss_assist_tb_top;
   logic        clock, reset, spr_req, spr_write, problem_state, tlb_int_take, tlb_int_is_fetch;
   logic        spr_ready, spr_done, spr_hit, spr_priv_fault, spr_invalid;
   logic        tlb_lru_wr, tlb_lru_sel_b, tlb_mrf_rd, tlb_mrf_wr;
   logic [9:0]  spr_field;
   logic [31:0] spr_wdata, spr_rdata, tlb_int_iaddr, tlb_int_daddr, tlb_int_status;
   logic [31:0] page_table_base, tlb_entry_hi, tlb_entry_lo, tlb_mrf_rdata, c1_lo, c1_hi;
   logic [23:0] seg_vsid;
   logic [3:0]  seg_index;
   logic [4:0]  tlb_set;
   logic [1:0]  tlb_way;
   logic [10:0] c1_ctl;
   int          num_errors, comparisons, cycles;

   spr_map_tlb_miss_assist u_spr_map_tlb_miss_assist
   (
      .clock(clock), .reset(reset), .spr_req(spr_req), .spr_write(spr_write),
      .spr_field(spr_field), .spr_wdata(spr_wdata), .problem_state(problem_state),
      .spr_ready(spr_ready), .spr_done(spr_done), .spr_hit(spr_hit),
      .spr_priv_fault(spr_priv_fault), .spr_invalid(spr_invalid), .spr_rdata(spr_rdata),
      .tlb_int_take(tlb_int_take), .tlb_int_is_fetch(tlb_int_is_fetch),
      .tlb_int_iaddr(tlb_int_iaddr), .tlb_int_daddr(tlb_int_daddr),
      .tlb_int_status(tlb_int_status), .page_table_base(page_table_base),
      .seg_index(seg_index), .seg_vsid(seg_vsid), .tlb_lru_wr(tlb_lru_wr),
      .tlb_lru_sel_b(tlb_lru_sel_b), .tlb_mrf_rd(tlb_mrf_rd), .tlb_mrf_wr(tlb_mrf_wr),
      .tlb_set(tlb_set), .tlb_way(tlb_way), .tlb_entry_hi(tlb_entry_hi),
      .tlb_entry_lo(tlb_entry_lo), .tlb_mrf_rdata(tlb_mrf_rdata)
   );

   // free-running core clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results

   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         results();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one move-to/from; the field carries the number with its halves swapped
   task automatic access(input logic wr, input logic [9:0] num, input logic [31:0] data,
                         input logic ps = 1'b0);
      @(posedge clock);
      #1;
      spr_req = 1'b1;
      spr_write = wr;
      spr_field = {num[4:0], num[9:5]};
      spr_wdata = data;
      problem_state = ps;
      @(posedge clock);
      #1;
      spr_req = 1'b0;
      check(32'(spr_ready), 32'h0);
      // TLB side pulses only last for this one cycle, so catch them here
      c1_ctl = {tlb_lru_wr, tlb_lru_sel_b, tlb_mrf_rd, tlb_mrf_wr, tlb_way, tlb_set};
      c1_lo = tlb_entry_lo;
      c1_hi = tlb_entry_hi;
      @(posedge clock);
      #1;
      check(32'(spr_done), 32'h1);
   endtask : access

   task automatic t_regs;
      int i;
      access(1'b0, `SPR_NUM_MISS_ADDRESS, 32'h0);
      check(spr_rdata, `MISS_ADDRESS_RESET);
      access(1'b0, `SPR_NUM_MISS_STATUS, 32'h0);
      check(spr_rdata, `MISS_STATUS_RESET);
      access(1'b1, `SPR_NUM_MISS_ADDRESS, 32'hA5A5_1234);
      access(1'b0, `SPR_NUM_MISS_ADDRESS, 32'h0);
      check(spr_rdata, 32'hA5A5_1234);
      check(32'(spr_hit), 32'h1);
      for (i = 0; i < 4; i++)
         access(1'b1, 10'(`SPR_NUM_SCRATCH_4 + i), 32'h5C00_0000 + 32'(i));
      for (i = 0; i < 4; i++)
      begin
         access(1'b0, 10'(`SPR_NUM_SCRATCH_4 + i), 32'h0);
         check(spr_rdata, 32'h5C00_0000 + 32'(i));
      end
      access(1'b0, 10'h001, 32'h0);
      check(32'(spr_hit), 32'h0);
      $display("test registers done");
   endtask : t_regs

   task automatic t_refuse;
      access(1'b1, `SPR_NUM_MISS_ADDRESS, 32'hDEAD_0000, 1'b1);
      check(32'(spr_priv_fault), 32'h1);
      access(1'b0, `SPR_NUM_MISS_ADDRESS, 32'h0);
      check(spr_rdata, 32'hA5A5_1234);
      access(1'b1, `SPR_NUM_PTE_COMPARE, 32'hFFFF_FFFF);
      check(32'(spr_invalid), 32'h1);
      access(1'b0, `SPR_NUM_LRU_WRITE_A, 32'h0);
      check(32'(spr_invalid), 32'h1);
      access(1'b0, `SPR_NUM_LRU_WRITE_B, 32'h0);
      check(32'(spr_invalid), 32'h1);
      $display("test refusals done");
   endtask : t_refuse

   task automatic t_capture;
      int f;
      for (f = 1; f >= 0; f--)
      begin
         @(posedge clock);
         #1;
         tlb_int_take = 1'b1;
         tlb_int_is_fetch = f[0];
         @(posedge clock);
         #1;
         tlb_int_take = 1'b0;
         access(1'b0, `SPR_NUM_MISS_ADDRESS, 32'h0);
         check(spr_rdata, f ? tlb_int_iaddr : tlb_int_daddr);
         access(1'b0, `SPR_NUM_MISS_STATUS, 32'h0);
         check(spr_rdata, tlb_int_status);
      end
      $display("test capture done");
   endtask : t_capture

   // compare word: valid one, segment id, hash id zero, page index from address
   task automatic t_derived;
      access(1'b0, `SPR_NUM_PTE_COMPARE, 32'h0);
      check(spr_rdata, {1'b1, seg_vsid, 1'b0, tlb_int_daddr[27:22]});
      check(32'(seg_index), 32'h7);
      seg_vsid = 24'h65_4321;
      access(1'b1, `SPR_NUM_MISS_ADDRESS, 32'h9ABC_D000);
      access(1'b0, `SPR_NUM_PTE_COMPARE, 32'h0);
      check(spr_rdata, {1'b1, 24'h65_4321, 1'b0, 6'h2A});
      check(32'(seg_index), 32'h9);
      // hash 54321 ^ ABCD = 5E8EC, mask zero, origin middle FF
      access(1'b0, `SPR_NUM_PTEG_PRIMARY, 32'h0);
      check(spr_rdata, 32'h00FF_3B00);
      access(1'b0, `SPR_NUM_PTEG_SECOND, 32'h0);
      check(spr_rdata, 32'h00FF_C4C0);
      $display("test derived words done");
   endtask : t_derived

   // address 9ABCD000 picks set 0D; way only moves on recent-fault access,
   // and the b-select flag holds until the next LRU write
   task automatic t_tlb;
      access(1'b1, `SPR_NUM_LRU_WRITE_A, 32'h1357_9BDF);
      check(32'(c1_ctl), {21'h0, 4'b1000, 2'h0, 5'h0D});
      check(c1_lo, 32'h1357_9BDF);
      check(c1_hi, {1'b1, 24'h65_4321, 1'b0, 6'h2A});
      access(1'b1, `SPR_NUM_LRU_WRITE_B, 32'h1357_9BDF);
      check(32'(c1_ctl), {21'h0, 4'b1100, 2'h0, 5'h0D});
      access(1'b1, `SPR_NUM_MISS_STATUS, 32'h0080_0000);
      access(1'b0, `SPR_NUM_RECENT_FAULT, 32'h0);
      check(32'(c1_ctl), {21'h0, 4'b0110, 2'h1, 5'h0D});
      check(spr_rdata, tlb_mrf_rdata);
      access(1'b1, `SPR_NUM_RECENT_FAULT, 32'h2468_ACE0);
      check(32'(c1_ctl), {21'h0, 4'b0101, 2'h1, 5'h0D});
      check(c1_lo, 32'h2468_ACE0);
      $display("test TLB writes done");
   endtask : t_tlb

   initial
   begin
      {spr_req, spr_write, problem_state, tlb_int_take, tlb_int_is_fetch} = 5'h0;
      spr_field = 10'h000;
      spr_wdata = 32'h0;
      tlb_int_iaddr = 32'h1234_5000;
      tlb_int_daddr = 32'h7654_3000;
      tlb_int_status = 32'h0100_0000;
      page_table_base = 32'h00FF_0000;
      seg_vsid = 24'h12_3456;
      tlb_mrf_rdata = 32'hC0DE_0042;
      reset = 1'b1;
      repeat (5) @(posedge clock);
      #1;
      reset = 1'b0;
      t_regs();
      t_refuse();
      t_capture();
      t_derived();
      t_tlb();
      results();
   end
endmodule : spr_map_tlb_miss_assist_tb_top
